// *** design/dmc_fifo.sv ***
// fifo with registered output stage
`timescale 1ns/100ps
module dmc_fifo #(
   parameter int unsigned WIDTH = 8,
   parameter int unsigned DEPTH = 32
) (
   input wire logic clock,
   input wire logic reset,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int unsigned AW = $clog2(DEPTH);
   localparam logic [AW:0] FULL_COUNT = (AW+1)'(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr_reg;
   logic [AW-1:0] rd_ptr_reg;
   logic [AW:0] count_reg;
   logic push;
   logic pop;

   assign in_ready = count_reg != FULL_COUNT;
   assign push = in_valid && in_ready;
   // refill the output stage when it is free or being taken
   assign pop = (count_reg != '0) && (!out_valid || out_ready);

   always_ff @(posedge clock) begin
      if (push) begin
         mem[wr_ptr_reg] <= in_data;
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg <= '0;
         out_valid <= 1'b0;
         out_data <= '0;
      end else begin
         wr_ptr_reg <= push ? wr_ptr_reg + 1'b1 : wr_ptr_reg;
         rd_ptr_reg <= pop ? rd_ptr_reg + 1'b1 : rd_ptr_reg;
         count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
         if (pop) begin
            out_valid <= 1'b1;
            out_data <= mem[rd_ptr_reg];
         end else if (out_ready) begin
            out_valid <= 1'b0;
         end
      end
   end
endmodule : dmc_fifo

// *** design/dmc_sticky_flag.sv ***
// sticky flag with set over clear priority
`timescale 1ns/100ps
module dmc_sticky_flag (
   input wire logic clock,
   input wire logic reset,
   input wire logic set,
   input wire logic clear,
   output logic q
);
   logic q_next;

   // a set in the clearing cycle is kept
   assign q_next = set ? 1'b1 : (clear ? 1'b0 : q);

   always_ff @(posedge clock) begin
      if (reset) begin
         q <= 1'b0;
      end else begin
         q <= q_next;
      end
   end
endmodule : dmc_sticky_flag

// *** design/dmc_top.sv ***
// debug message channel with avalon-mm register slave
// Functional notes
// - A cpu write to the message register stores the byte for the debugger to fetch.
// - Every cpu write to the message register sets the dirty flag at that same edge.
// - A cpu read of the message register gives its low seven bits with the dirty flag on top.
// - The shared address reaches the message register only with fuse and grant, else the io register.
//
// The implementer's own choices: the address map and the Avalon-MM slave port.
`timescale 1ns/100ps
module dmc_top (
   input wire logic clock,
   input wire logic reset,
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic debug_enable_fuse,
   input wire logic dbg_grant,
   input wire logic dbg_clear,
   output logic [7:0] dbg_message,
   output logic debug_data_dirty_flag,
   output logic dbg_stream_valid,
   input wire logic dbg_stream_ready,
   output logic [7:0] dbg_stream_data,
   output logic [7:0] io_shared_out
);
   dmc_pkg::dmc_req_t req;
   dmc_pkg::dmc_bus_state_t state_reg;
   dmc_pkg::dmc_bus_state_t state_next;
   dmc_pkg::dmc_status_t status_word;

   logic [7:0] debug_message_register;
   logic [7:0] io_shared_reg;
   logic ctrl_stream_reg;
   logic route_latched_reg;
   logic waitrequest_reg;
   logic [31:0] readdata_reg;
   logic [31:0] readdata_next;

   logic is_idle;
   logic sel_message;
   logic sel_status;
   logic sel_control;
   logic route_debug;
   logic to_message;
   logic push_needed;
   logic can_ack;
   logic accept;
   logic commit;
   logic wr_commit;
   logic msg_wr;
   logic io_wr;
   logic ctrl_wr;
   logic dirty_q;
   logic fifo_in_ready;
   logic fifo_push;
   logic [31:0] message_word;
   logic [31:0] control_word;

   // request as one bundle
   assign req = '{
      addr: avs_address,
      read: avs_read,
      write: avs_write,
      wdata: avs_writedata
   };

   // address decode
   assign is_idle = state_reg == dmc_pkg::DMC_IDLE;
   assign sel_message = req.addr == dmc_pkg::OFF_MESSAGE;
   assign sel_status = req.addr == dmc_pkg::OFF_STATUS;
   assign sel_control = req.addr == dmc_pkg::OFF_CONTROL;

   // message register only with fuse and debugger grant
   assign route_debug = debug_enable_fuse && dbg_grant;
   assign to_message = sel_message && route_debug;

   // a streamed message waits for room in the fifo
   assign push_needed = to_message && req.write && ctrl_stream_reg;
   assign can_ack = !push_needed || fifo_in_ready;
   assign accept = is_idle && (req.read || req.write) && can_ack;

   // master holds the request until it sees waitrequest low
   assign commit = state_reg == dmc_pkg::DMC_ACK;
   assign wr_commit = commit && req.write;
   assign msg_wr = wr_commit && sel_message && route_latched_reg;
   assign io_wr = wr_commit && sel_message && !route_latched_reg;
   assign ctrl_wr = wr_commit && sel_control;
   assign fifo_push = msg_wr && ctrl_stream_reg;

   // read views
   assign message_word = {24'h00_0000, dirty_q, debug_message_register[6:0]};
   assign control_word = {31'h0000_0000, ctrl_stream_reg};
   assign status_word = '{
      zero: '0,
      route: route_debug,
      fuse: debug_enable_fuse,
      full: !fifo_in_ready,
      nonempty: dbg_stream_valid,
      dirty: dirty_q
   };

   // read data mux
   assign readdata_next = !accept ? readdata_reg :
      !req.read ? dmc_pkg::UNMAPPED_READ :
      to_message ? message_word :
      sel_message ? {24'h00_0000, io_shared_reg} :
      sel_status ? 32'(status_word) :
      sel_control ? control_word :
      dmc_pkg::UNMAPPED_READ;

   // one request in flight, released one edge after it was taken
   assign state_next = accept ? dmc_pkg::DMC_ACK : dmc_pkg::DMC_IDLE;

   always_ff @(posedge clock) begin
      if (reset) begin
         state_reg <= dmc_pkg::DMC_IDLE;
         waitrequest_reg <= 1'b1;
         readdata_reg <= dmc_pkg::UNMAPPED_READ;
         route_latched_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         waitrequest_reg <= !accept;
         readdata_reg <= readdata_next;
         route_latched_reg <= accept ? route_debug : route_latched_reg;
      end
   end

   // message byte capture
   always_ff @(posedge clock) begin
      if (reset) begin
         debug_message_register <= dmc_pkg::MESSAGE_RESET;
      end else if (msg_wr) begin
         debug_message_register <= req.wdata[7:0];
      end
   end

   // ordinary io register behind the shared address
   always_ff @(posedge clock) begin
      if (reset) begin
         io_shared_reg <= dmc_pkg::IO_SHARED_RESET;
      end else if (io_wr) begin
         io_shared_reg <= req.wdata[7:0];
      end
   end

   // control: streaming of messages into the fifo
   always_ff @(posedge clock) begin
      if (reset) begin
         ctrl_stream_reg <= dmc_pkg::CTRL_STREAM_RESET;
      end else if (ctrl_wr) begin
         ctrl_stream_reg <= req.wdata[dmc_pkg::CTRL_STREAM_BIT];
      end
   end

   // dirty flag, set by cpu write, cleared by debugger
   dmc_sticky_flag u_dirty (
      .clock(clock),
      .reset(reset),
      .set(msg_wr),
      .clear(dbg_clear),
      .q(dirty_q)
   );

   // message stream towards the debugger
   dmc_fifo #(
      .WIDTH(dmc_pkg::MSG_WIDTH),
      .DEPTH(dmc_pkg::FIFO_DEPTH)
   ) u_fifo (
      .clock(clock),
      .reset(reset),
      .in_valid(fifo_push),
      .in_ready(fifo_in_ready),
      .in_data(req.wdata[7:0]),
      .out_valid(dbg_stream_valid),
      .out_ready(dbg_stream_ready),
      .out_data(dbg_stream_data)
   );

   assign avs_readdata = readdata_reg;
   assign avs_waitrequest = waitrequest_reg;
   assign dbg_message = debug_message_register;
   assign debug_data_dirty_flag = dirty_q;
   assign io_shared_out = io_shared_reg;

   // checks
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (reset);

   sequence msg_write_s;
      msg_wr;
   endsequence

   sequence msg_read_taken_s;
      accept && req.read && to_message;
   endsequence

   sequence handshake_s;
      !avs_waitrequest ##1 avs_waitrequest;
   endsequence

   message_capture_a: assert property (
      msg_write_s |=> dbg_message == $past(avs_writedata[7:0])
   ) else $error("message byte not captured on write");

   dirty_set_a: assert property (
      msg_write_s |=> debug_data_dirty_flag && !avs_waitrequest == 1'b0
   ) else $error("dirty flag not set by message write");

   read_format_a: assert property (
      msg_read_taken_s |=> !avs_waitrequest &&
         avs_readdata == {24'h00_0000, $past(dirty_q), $past(debug_message_register[6:0])}
   ) else $error("message read word malformed");

   dirty_clear_a: assert property (
      dbg_clear && !msg_wr |=> !debug_data_dirty_flag
   ) else $error("dirty flag not cleared by debugger");

   route_io_a: assert property (
      accept && req.write && sel_message && !route_debug |=>
         ##1 dbg_message == $past(dbg_message, 2) && io_shared_out == $past(avs_writedata[7:0])
   ) else $error("shared address write reached wrong register");

   route_msg_a: assert property (
      accept && req.write && to_message |=>
         ##1 io_shared_out == $past(io_shared_out, 2) && debug_data_dirty_flag
   ) else $error("granted write did not reach message register");

   reset_clear_a: assert property (
      @(posedge clock) disable iff (1'b0)
      reset |=> dbg_message == dmc_pkg::MESSAGE_RESET && !debug_data_dirty_flag
   ) else $error("reset left a stale message");

   bus_handshake_a: assert property (
      accept |=> handshake_s
   ) else $error("waitrequest not low for exactly one cycle");

   full_stall_a: assert property (
      push_needed && is_idle && !fifo_in_ready |=> avs_waitrequest
   ) else $error("message write acknowledged while fifo full");

   sequence io_read_taken_s;
      accept && req.read && sel_message && !route_debug;
   endsequence

   sequence unmapped_read_taken_s;
      accept && req.read && !sel_message && !sel_status && !sel_control;
   endsequence

   sequence stream_held_s;
      dbg_stream_valid && !dbg_stream_ready;
   endsequence

   // registers change only on their own commit, the dirty flag also on a debugger clear
   message_hold_a: assert property (
      !msg_wr |=> dbg_message == $past(dbg_message)
   ) else $error("message byte changed without a write");

   dirty_hold_a: assert property (
      !msg_wr && !dbg_clear |=> debug_data_dirty_flag == $past(debug_data_dirty_flag)
   ) else $error("dirty flag changed without cause");

   io_hold_a: assert property (
      !io_wr |=> io_shared_out == $past(io_shared_out)
   ) else $error("io register changed without a write");

   io_read_a: assert property (
      io_read_taken_s |=> !avs_waitrequest &&
         avs_readdata == {24'h00_0000, $past(io_shared_out)}
   ) else $error("ungranted read did not reach io register");

   unmapped_read_a: assert property (
      unmapped_read_taken_s |=> !avs_waitrequest && avs_readdata == dmc_pkg::UNMAPPED_READ
   ) else $error("unmapped read returned data");

   status_read_a: assert property (
      accept && req.read && sel_status |=> !avs_waitrequest &&
         avs_readdata[0] == $past(debug_data_dirty_flag) &&
         avs_readdata[1] == $past(dbg_stream_valid) &&
         avs_readdata[31:5] == 27'h000_0000
   ) else $error("status word malformed");

   // no byte is lost on the stream side
   fifo_room_a: assert property (
      fifo_push |-> fifo_in_ready
   ) else $error("streamed message pushed into a full fifo");

   stream_hold_a: assert property (
      stream_held_s |=> dbg_stream_valid && dbg_stream_data == $past(dbg_stream_data)
   ) else $error("stream byte dropped before it was taken");

   wait_idle_a: assert property (
      !accept |=> avs_waitrequest
   ) else $error("waitrequest low without an accepted request");

   reset_bus_a: assert property (
      @(posedge clock) disable iff (1'b0)
      reset |=> avs_waitrequest && !dbg_stream_valid &&
         io_shared_out == dmc_pkg::IO_SHARED_RESET
   ) else $error("reset left the bus or stream busy");
endmodule : dmc_top

// *** pkg/dmc_pkg.sv ***
// constants and types for the debug message channel
package dmc_pkg;
   // register bus geometry
   localparam int unsigned ADDR_WIDTH = 4;
   localparam int unsigned DATA_WIDTH = 32;
   localparam int unsigned MSG_WIDTH = 8;
   localparam int unsigned FIFO_DEPTH = 32;

   // byte offsets of the register words
   localparam logic [3:0] OFF_MESSAGE = 4'h0;
   localparam logic [3:0] OFF_STATUS = 4'h4;
   localparam logic [3:0] OFF_CONTROL = 4'h8;

   // field positions
   localparam int unsigned DIRTY_BIT = 7;
   localparam int unsigned CTRL_STREAM_BIT = 0;

   // reset values
   localparam logic [7:0] MESSAGE_RESET = 8'h00;
   localparam logic [7:0] IO_SHARED_RESET = 8'h00;
   localparam logic CTRL_STREAM_RESET = 1'b1;
   localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;

   // bus slave states
   typedef enum logic [0:0] {
      DMC_IDLE = 1'b0,
      DMC_ACK = 1'b1
   } dmc_bus_state_t;

   // one register request as the master presents it
   typedef struct packed {
      logic [3:0] addr;
      logic read;
      logic write;
      logic [31:0] wdata;
   } dmc_req_t;

   // status word layout
   typedef struct packed {
      logic [26:0] zero;
      logic route;
      logic fuse;
      logic full;
      logic nonempty;
      logic dirty;
   } dmc_status_t;
endpackage : dmc_pkg

// *** testbench/dmc_debugger_model.sv ***
// debugger-side model: fetches message bytes and drains the stream
`timescale 1ns/100ps
module dmc_debugger_model (
   input wire logic clock,
   input wire logic reset,
   input wire logic debug_data_dirty_flag,
   input wire logic [7:0] dbg_message,
   input wire logic fetch_en,
   input wire logic stall,
   output logic dbg_clear,
   output logic dbg_stream_ready,
   output logic [7:0] fetched_reg
);
   assign dbg_stream_ready = !stall;
   // take the byte first, then clear the flag for one cycle
   always_ff @(posedge clock) begin
      if (reset) begin
         dbg_clear <= 1'b0;
         fetched_reg <= 8'h00;
      end else if (fetch_en && debug_data_dirty_flag && !dbg_clear) begin
         fetched_reg <= dbg_message;
         dbg_clear <= 1'b1;
      end else begin
         dbg_clear <= 1'b0;
      end
   end
endmodule : dmc_debugger_model

// *** testbench/dmc_top_tb.sv ***
// self-checking bench for the debug message channel
`timescale 1ns/100ps
module dmc_top_tb;
   logic clock = 1'b0;
   logic reset = 1'b1;
   logic [3:0] avs_address = 4'h0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic fuse = 1'b1;
   logic grant = 1'b1;
   logic fetch_en = 1'b0;
   logic stall = 1'b0;
   logic dbg_clear;
   logic ready;
   logic valid;
   logic dirty;
   logic [7:0] msg;
   logic [7:0] sdata;
   logic [7:0] io;
   logic [7:0] fetched;
   logic [7:0] got_q[$];
   logic [31:0] rd;
   int error_cnt = 0;
   int checked = 0;
   always #4 clock = ~clock;
   dmc_top dut (.clock(clock), .reset(reset), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .debug_enable_fuse(fuse), .dbg_grant(grant), .dbg_clear(dbg_clear),
      .dbg_message(msg), .debug_data_dirty_flag(dirty), .dbg_stream_valid(valid),
      .dbg_stream_ready(ready), .dbg_stream_data(sdata), .io_shared_out(io));
   dmc_debugger_model dbg (.clock(clock), .reset(reset), .debug_data_dirty_flag(dirty),
      .dbg_message(msg), .fetch_en(fetch_en), .stall(stall), .dbg_clear(dbg_clear),
      .dbg_stream_ready(ready), .fetched_reg(fetched));
   always @(posedge clock) begin
      if (valid === 1'b1 && ready === 1'b1) got_q.push_back(sdata);
   end
   task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : chk
   // one avalon cycle, held until waitrequest is sampled low
   task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      @(posedge clock);
      while (avs_waitrequest !== 1'b0) @(posedge clock);
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      @(posedge clock);
   endtask : bus
   task t_reset_values;
      chk(msg, 32'h0, "msg");
      chk(dirty, 32'h0, "dirty");
      chk(io, 32'h0, "io");
      bus(1'b0, dmc_pkg::OFF_MESSAGE, 32'h0);
      chk(rd, 32'h0, "reset read");
   endtask : t_reset_values
   task t_write_read;
      bus(1'b1, dmc_pkg::OFF_MESSAGE, 32'h2a);
      chk(msg, 32'h2a, "msg");
      chk(dirty, 32'h1, "dirty set");
      bus(1'b0, dmc_pkg::OFF_MESSAGE, 32'h0);
      chk(rd, 32'haa, "read");
      bus(1'b1, dmc_pkg::OFF_MESSAGE, 32'h11);
      bus(1'b1, dmc_pkg::OFF_MESSAGE, 32'h22);
      bus(1'b0, dmc_pkg::OFF_MESSAGE, 32'h0);
      chk(rd, 32'ha2, "b2b read");
      fetch_en <= 1'b1;
      repeat (4) @(posedge clock);
      chk(fetched, 32'h22, "fetched");
      chk(dirty, 32'h0, "dirty clear");
      bus(1'b1, dmc_pkg::OFF_MESSAGE, 32'h81);
      repeat (4) @(posedge clock);
      bus(1'b0, dmc_pkg::OFF_MESSAGE, 32'h0);
      chk(rd, 32'h01, "read cleared");
      fetch_en <= 1'b0;
   endtask : t_write_read
   task t_routing;
      logic [7:0] em;
      logic [7:0] ei;
      em = 8'h81;
      ei = 8'h00;
      for (int i = 0; i < 4; i++) begin
         fuse <= i[0];
         grant <= i[1];
         @(posedge clock);
         bus(1'b1, dmc_pkg::OFF_MESSAGE, 32'h40 + i);
         if (i == 3) em = 8'h43;
         else ei = 8'h40 + i;
         chk(msg, em, "route msg");
         chk(io, ei, "route io");
         bus(1'b0, dmc_pkg::OFF_MESSAGE, 32'h0);
         chk(rd, (i == 3) ? 32'h0000_00c3 : {24'h00_0000, ei}, "route read");
      end
      bus(1'b1, 4'hc, 32'hff);
      bus(1'b0, 4'hc, 32'h0);
      chk(rd, dmc_pkg::UNMAPPED_READ, "unmapped");
   endtask : t_routing
   task t_fifo;
      stall <= 1'b1;
      repeat (4) @(posedge clock);
      got_q.delete();
      for (int i = 0; i < 33; i++) bus(1'b1, dmc_pkg::OFF_MESSAGE, i);
      bus(1'b0, dmc_pkg::OFF_STATUS, 32'h0);
      chk(rd[2], 32'h1, "full");
      chk(got_q.size(), 32'h0, "stalled");
      fork
         bus(1'b1, dmc_pkg::OFF_MESSAGE, 32'h21);
         begin
            repeat (6) @(posedge clock);
            chk(avs_waitrequest, 32'h1, "write held while full");
            stall <= 1'b0;
         end
      join
      repeat (40) @(posedge clock);
      chk(got_q.size(), 32'd34, "drained");
      for (int i = 0; i < got_q.size(); i++) chk(got_q[i], i, "order");
      bus(1'b1, dmc_pkg::OFF_CONTROL, 32'h0);
      bus(1'b1, dmc_pkg::OFF_MESSAGE, 32'h77);
      repeat (4) @(posedge clock);
      chk(got_q.size(), 32'd34, "stream off");
      chk(msg, 32'h77, "msg stream off");
      bus(1'b1, dmc_pkg::OFF_CONTROL, 32'h1);
   endtask : t_fifo
   task t_reset_mid;
      bus(1'b1, dmc_pkg::OFF_MESSAGE, 32'h5c);
      reset <= 1'b1;
      repeat (2) @(posedge clock);
      reset <= 1'b0;
      @(posedge clock);
      chk(msg, 32'h0, "msg after reset");
      chk(dirty, 32'h0, "dirty after reset");
      chk(valid, 32'h0, "valid after reset");
   endtask : t_reset_mid
   task tally_and_finish;
      $display("errors %0d checks %0d", error_cnt, checked);
      if (error_cnt == 0 && checked > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : tally_and_finish
   initial begin
      #200000;
      error_cnt++;
      tally_and_finish;
   end
   initial begin
      repeat (16) @(posedge clock);
      reset <= 1'b0;
      @(posedge clock);
      t_reset_values;
      t_write_read;
      t_routing;
      t_fifo;
      t_reset_mid;
      tally_and_finish;
   end
endmodule : dmc_top_tb
